// file: wdtlk_pkg.sv
// Package: constants for the locked-mode watchdog block
package wdtlk_pkg;
   // Expanded register bank and offset of the mode register
   localparam logic [3:0] WDTLK_MODE_BANK = 4'hF;
   localparam logic [7:0] WDTLK_MODE_ADDR = 8'h0F;
   // Mode register field positions
   localparam int WDTLK_TAP_LSB = 0;
   localparam int WDTLK_TAP_MSB = 1;
   localparam int WDTLK_HALT_BIT = 2;
   localparam int WDTLK_STOP_BIT = 3;
   // Mode register reset default (tap 0, run in halt, stop in stop)
   localparam logic [7:0] WDTLK_MODE_RST = 8'h04;
   // Write window: processor cycles after first instruction
   localparam int WDTLK_WIN_CYC = 60;
   // Core cycles per processor cycle (two crystal clocks each)
   localparam int WDTLK_CORE_PER_PCYC = 2;
   localparam int WDTLK_WIN_CLK = WDTLK_WIN_CYC * WDTLK_CORE_PER_PCYC;
   // Default timeout per tap, in RC oscillator ticks
   localparam int WDTLK_TAP0_TICKS = 256;
   localparam int WDTLK_TAP1_TICKS = 512;
   localparam int WDTLK_TAP2_TICKS = 1024;
   localparam int WDTLK_TAP3_TICKS = 4096;
   // Width of the watchdog down counter
   localparam int WDTLK_CNT_W = 16;
   // Reset pulse length in core clocks
   localparam int WDTLK_RST_CLK = 4;
   // Watchdog state
   typedef enum logic [1:0] {
      WDTLK_IDLE,
      WDTLK_RUN,
      WDTLK_FIRE
   } wdtlk_state_e;
endpackage

// file: wdtlk_sync.sv
// Two flip-flop synchroniser for the RC oscillator level
`timescale 1ns/1ps
`default_nettype none
module wdtlk_sync (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Asynchronous level in, synchronised level out
   input wire logic i_async,
   output logic o_sync
);
   logic meta_r; // First stage, read only by second
   logic sync_r; // Second stage
   logic meta_nxt;
   logic sync_nxt;

   // Next values
   always_comb begin
      meta_nxt = i_async;
      sync_nxt = meta_r;
   end

   // Register stages
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign o_sync = sync_r;
endmodule
`default_nettype wire

// file: wdtlk_lock.sv
// Mode register with its post-reset write window and lock
`timescale 1ns/1ps
`default_nettype none
module wdtlk_lock
   import wdtlk_pkg::*;
#(
   parameter logic [7:0] MODE_RST = WDTLK_MODE_RST
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Window start: first instruction after reset or recovery
   input wire logic i_win_start,
   // Register write strobe and data
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   // Stored mode and window state
   output logic [7:0] o_mode,
   output logic o_open
);
   logic [7:0] mode_r; // Stored mode bits
   logic [7:0] mode_nxt;
   logic [7:0] win_r; // Remaining window clocks
   logic [7:0] win_nxt;
   logic open_r; // Window open flag
   logic open_nxt;

   // Window countdown and guarded write
   always_comb begin
      mode_nxt = mode_r;
      win_nxt = win_r;
      open_nxt = open_r;
      if (i_win_start) begin
         // Reopen for a fresh window
         win_nxt = 8'(WDTLK_WIN_CLK - 1);
         open_nxt = 1'b1;
      end else if (open_r) begin
         if (win_r == 8'h00) begin
            open_nxt = 1'b0;
         end else begin
            win_nxt = win_r - 8'h01;
         end
      end
      // Writes only while open
      if (i_wr && open_r) begin
         mode_nxt = i_wdata;
      end
   end

   // Register window state
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         mode_r <= MODE_RST;
         win_r <= 8'h00;
         open_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         win_r <= win_nxt;
         open_r <= open_nxt;
      end
   end

   assign o_mode = mode_r;
   assign o_open = open_r;

   // Locked register never changes
   AST_LOCK_HOLD: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) !open_r && !i_win_start |=> $stable(mode_r))
      else $error("mode changed while locked");
   // Window still open eight clocks after its start
   AST_WIN_LEN: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) i_win_start ##1 (!i_win_start) [*8]
      |-> open_r)
      else $error("window closed too early");
endmodule
`default_nettype wire

// file: wdtlk_top.sv
// Watchdog timer with locked mode register, core side
`timescale 1ns/1ps
`default_nettype none
// How it works
// - One-shot counter; terminal count resets core
// - Idle until first watchdog instruction enables
// - Later instructions reload the full timeout
// - Counts only on RC oscillator ticks
// - Instruction updates zero, sign, overflow flags
// - Low two mode bits pick timeout tap
// - Bit 2 decides counting during halt
// - Bit 3 decides counting during stop
// - Bits 4 to 7 are ignored
// - Writes accepted first 60 processor cycles only
// - Later writes ignored until next reset
// - Mode register is write only
// - Mode register at bank F offset 0Fh
module wdtlk_top
   import wdtlk_pkg::*;
#(
   parameter int TAP0_TICKS = WDTLK_TAP0_TICKS,
   parameter int TAP1_TICKS = WDTLK_TAP1_TICKS,
   parameter int TAP2_TICKS = WDTLK_TAP2_TICKS,
   parameter int TAP3_TICKS = WDTLK_TAP3_TICKS,
   parameter logic [7:0] MODE_RST = WDTLK_MODE_RST
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // RC oscillator (asynchronous level)
   input wire logic i_rc_osc,
   // Core status
   input wire logic i_first_instr,
   input wire logic i_halt,
   input wire logic i_stop,
   // Watchdog instruction strobe
   input wire logic i_wdt_exec,
   // Register access
   input wire logic [3:0] i_bank,
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_rd_hit,
   // Flag update to the core
   output logic o_flag_we,
   output logic o_flag_z,
   output logic o_flag_s,
   output logic o_flag_v,
   // Watchdog reset of the core
   output logic o_wdt_rst,
   // Status
   output logic o_active,
   output logic o_win_open
);
   logic rc_sync; // Synchronised RC level
   logic rc_prev_r; // Previous RC level
   logic rc_prev_nxt;
   logic rc_tick; // One RC rising edge
   logic [7:0] mode; // Stored mode bits
   logic mode_wr; // Decoded register write
   wdtlk_state_e st_r; // Watchdog state
   wdtlk_state_e st_nxt;
   logic [WDTLK_CNT_W-1:0] cnt_r; // Down counter
   logic [WDTLK_CNT_W-1:0] cnt_nxt;
   logic [2:0] rst_cnt_r; // Reset pulse length
   logic [2:0] rst_cnt_nxt;
   logic flag_we_r; // Flag update strobe
   logic flag_we_nxt;
   logic win_start_r; // Window start after watchdog reset
   logic win_start_nxt;
   logic run_ok; // Counting allowed now

   // Register decode, used for write and read
   function automatic logic reg_hit(input logic [3:0] bank,
                                    input logic [7:0] addr);
      reg_hit = (bank == WDTLK_MODE_BANK) && (addr == WDTLK_MODE_ADDR);
   endfunction

   // Timeout load for a tap
   function automatic logic [WDTLK_CNT_W-1:0] tap_load(input logic [1:0] t);
      case (t)
         2'h0: tap_load = WDTLK_CNT_W'(TAP0_TICKS - 1);
         2'h1: tap_load = WDTLK_CNT_W'(TAP1_TICKS - 1);
         2'h2: tap_load = WDTLK_CNT_W'(TAP2_TICKS - 1);
         default: tap_load = WDTLK_CNT_W'(TAP3_TICKS - 1);
      endcase
   endfunction

   // RC oscillator synchroniser
   wdtlk_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_rc_osc),
      .o_sync(rc_sync)
   );

   assign mode_wr = i_wr && reg_hit(i_bank, i_addr);

   // Mode register with write window
   wdtlk_lock #(
      .MODE_RST(MODE_RST)
   ) u_lock (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_win_start(i_first_instr || win_start_r),
      .i_wr(mode_wr),
      .i_wdata(i_wdata),
      .o_mode(mode),
      .o_open(o_win_open)
   );

   // RC edge detect on synchronised level
   always_comb begin
      rc_prev_nxt = rc_sync;
   end
   assign rc_tick = rc_sync && !rc_prev_r;

   // Halt and stop gating from mode bits 2 and 3; bits 4-7 unused
   assign run_ok = (!i_halt || mode[WDTLK_HALT_BIT]) &&
                   (!i_stop || mode[WDTLK_STOP_BIT]);

   // Watchdog state and counter next values
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      rst_cnt_nxt = rst_cnt_r;
      flag_we_nxt = i_wdt_exec;
      win_start_nxt = 1'b0;
      case (st_r)
         WDTLK_IDLE: begin
            if (i_wdt_exec) begin
               // First instruction starts the watchdog
               st_nxt = WDTLK_RUN;
               cnt_nxt = tap_load(mode[WDTLK_TAP_MSB:WDTLK_TAP_LSB]);
            end
         end
         WDTLK_RUN: begin
            if (i_wdt_exec) begin
               cnt_nxt = tap_load(mode[WDTLK_TAP_MSB:WDTLK_TAP_LSB]);
            end else if (rc_tick && run_ok) begin
               if (cnt_r == '0) begin
                  // Terminal count fires the reset
                  st_nxt = WDTLK_FIRE;
                  rst_cnt_nxt = 3'(WDTLK_RST_CLK - 1);
               end else begin
                  cnt_nxt = cnt_r - 1'b1;
               end
            end
         end
         WDTLK_FIRE: begin
            if (rst_cnt_r == 3'h0) begin
               // Back to idle; window reopens
               st_nxt = WDTLK_IDLE;
               win_start_nxt = 1'b1;
            end else begin
               rst_cnt_nxt = rst_cnt_r - 3'h1;
            end
         end
         default: st_nxt = WDTLK_IDLE;
      endcase
   end

   // Register state
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_r <= WDTLK_IDLE;
         cnt_r <= '0;
         rst_cnt_r <= 3'h0;
         flag_we_r <= 1'b0;
         win_start_r <= 1'b0;
         rc_prev_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         rst_cnt_r <= rst_cnt_nxt;
         flag_we_r <= flag_we_nxt;
         win_start_r <= win_start_nxt;
         rc_prev_r <= rc_prev_nxt;
      end
   end

   // Outputs
   assign o_wdt_rst = (st_r == WDTLK_FIRE);
   assign o_active = (st_r != WDTLK_IDLE);
   assign o_flag_we = flag_we_r;
   // Flag values: result undefined, reported as cleared
   assign o_flag_z = 1'b0;
   assign o_flag_s = 1'b0;
   assign o_flag_v = 1'b0;
   // Reads of the mode register return zero
   assign o_rdata = 8'h00;
   assign o_rd_hit = i_rd && reg_hit(i_bank, i_addr);

   // Named steps for the terminal-count sequence
   sequence s_expire;
      st_r == WDTLK_RUN && !i_wdt_exec && rc_tick && run_ok &&
         cnt_r == '0;
   endsequence
   sequence s_pulse;
      o_wdt_rst [*4] ##1 !o_wdt_rst;
   endsequence

   AST_EXPIRE_RST: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) s_expire |=> s_pulse)
      else $error("no reset pulse after terminal count");
   AST_IDLE_QUIET: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_IDLE && !i_wdt_exec |=>
      st_r == WDTLK_IDLE)
      else $error("watchdog started without instruction");
   AST_REFRESH: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_RUN && i_wdt_exec |=>
      cnt_r == tap_load($past(mode[1:0])) && !o_wdt_rst)
      else $error("refresh did not reload count");
   AST_NO_TICK: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_RUN && !rc_tick && !i_wdt_exec |=>
      $stable(cnt_r))
      else $error("count moved without oscillator tick");
   AST_FLAGS: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) i_wdt_exec |=> o_flag_we)
      else $error("flag update missing");
   AST_HALT_HOLD: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_RUN && i_halt && !mode[2] &&
      !i_wdt_exec |=> $stable(cnt_r))
      else $error("counted during halt");
   AST_STOP_HOLD: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_RUN && i_stop && !mode[3] &&
      !i_wdt_exec |=> $stable(cnt_r))
      else $error("counted during stop");
   AST_READ_ZERO: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) o_rd_hit |-> o_rdata == 8'h00)
      else $error("mode register readable");

   // Flag strobe carries cleared flag values
   AST_FLAG_CLR: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) o_flag_we |->
      !o_flag_z && !o_flag_s && !o_flag_v)
      else $error("flag values not cleared");

   // Flag strobe only follows an instruction
   AST_FLAG_ONE: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) !i_wdt_exec |=> !o_flag_we)
      else $error("flag strobe without instruction");

   // First instruction enables and loads the tap
   AST_FIRST_LOAD: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_IDLE && i_wdt_exec |=>
      st_r == WDTLK_RUN && cnt_r == tap_load($past(mode[1:0])))
      else $error("first instruction did not load");

   // Each allowed tick above zero takes one off the count
   AST_TICK_DEC: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_RUN && !i_wdt_exec && rc_tick &&
      run_ok && cnt_r != '0 |=> cnt_r == $past(cnt_r) - 1)
      else $error("tick did not decrement");

   // Counting goes on in halt when bit 2 is set
   AST_HALT_RUN: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_RUN && i_halt && mode[2] && !i_stop &&
      rc_tick && !i_wdt_exec && cnt_r != '0 |=> $changed(cnt_r))
      else $error("halted despite run in halt");

   // Counting goes on in stop when bit 3 is set
   AST_STOP_RUN: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_RUN && i_stop && mode[3] && !i_halt &&
      rc_tick && !i_wdt_exec && cnt_r != '0 |=> $changed(cnt_r))
      else $error("stopped despite run in stop");

   // End of the reset pulse reopens the write window
   AST_FIRE_REOPEN: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) st_r == WDTLK_FIRE && rst_cnt_r == 3'h0 |=>
      st_r == WDTLK_IDLE ##1 o_win_open)
      else $error("window not reopened after reset");

   // Reads elsewhere never claim the mode register
   AST_RD_MISS: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) i_rd && !reg_hit(i_bank, i_addr) |-> !o_rd_hit)
      else $error("read hit on wrong location");

   // Mode only moves on a decoded write
   AST_WR_MISS: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) !mode_wr |=> $stable(mode))
      else $error("mode changed without decoded write");

   // Open window takes the written byte
   AST_WR_TAKE: assert property (@(posedge i_core_clk) disable iff
      (i_sys_rst) mode_wr && o_win_open |=> mode == $past(i_wdata))
      else $error("write in open window lost");
endmodule
`default_nettype wire

// file: wdtlk_core_model.sv
// Core-side partner: RC oscillator and first-instruction pulse
`timescale 1ns/1ps
`default_nettype none
module wdtlk_core_model (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Power-on start request, watchdog reset seen
   input wire logic i_start,
   input wire logic i_wdt_rst,
   // Toward the watchdog
   output logic o_rc_osc,
   output logic o_first_instr
);
   logic rst_q_r; // Previous watchdog reset level
   // Free-running RC oscillator, phase unrelated to core
   initial begin
      o_rc_osc = 1'b0;
      #7;
      forever #165 o_rc_osc = ~o_rc_osc;
   end
   // First instruction after power-on or watchdog reset
   always_ff @(posedge i_core_clk) begin
      rst_q_r <= i_wdt_rst;
      o_first_instr <= !i_sys_rst &&
         (i_start || (rst_q_r && !i_wdt_rst));
   end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the locked-mode watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import wdtlk_pkg::*;
   // Short tap lengths in RC ticks
   localparam int T0 = 4;
   localparam int T1 = 5;
   localparam int T2 = 6;
   localparam int T3 = 8;
   int tk[4] = '{T0, T1, T2, T3};
   logic clk, rc, first, hit, fwe, fz, fs, fv, wrst, act, wopen;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic halt = 1'b0;
   logic stop = 1'b0;
   logic exec = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] bank = 4'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   int fails = 0;
   int n_tests = 0;
   int edges = 0;
   int opens = 0;
   int rsts = 0;
   int rlen = 0;
   int r0;
   // Core clock, 40 ns
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   wdtlk_top #(.TAP0_TICKS(T0), .TAP1_TICKS(T1), .TAP2_TICKS(T2),
      .TAP3_TICKS(T3)) u_dut (.i_core_clk(clk), .i_sys_rst(rst),
      .i_rc_osc(rc), .i_first_instr(first), .i_halt(halt),
      .i_stop(stop), .i_wdt_exec(exec), .i_bank(bank), .i_addr(addr),
      .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
      .o_rd_hit(hit), .o_flag_we(fwe), .o_flag_z(fz), .o_flag_s(fs),
      .o_flag_v(fv), .o_wdt_rst(wrst), .o_active(act),
      .o_win_open(wopen));
   wdtlk_core_model u_core (.i_core_clk(clk), .i_sys_rst(rst),
      .i_start(start), .i_wdt_rst(wrst), .o_rc_osc(rc),
      .o_first_instr(first));
   // Event counters: RC edges, open cycles, reset pulses
   always @(posedge rc) edges++;
   always @(posedge wrst) rsts++;
   always @(posedge clk) begin
      if (wopen === 1'b1) opens++;
      if (wrst === 1'b1) rlen++;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [7:0] s, e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s: expected %0h, seen %0h", nm, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One register write strobe
   task automatic wreg(input logic [7:0] v);
      @(posedge clk);
      bank <= WDTLK_MODE_BANK;
      addr <= WDTLK_MODE_ADDR;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Watchdog instruction, with flag answer one cycle on
   task automatic kick();
      @(posedge clk);
      exec <= 1'b1;
      @(posedge clk);
      exec <= 1'b0;
      #1;
      chk("flag we", fwe, 1);
      chk("flags", {fz, fs, fv}, 0);
      chk("active", act, 1);
   endtask
   // Start, let it expire, count RC ticks and pulse length
   task automatic meas(input int n);
      int e0;
      @(posedge rc);
      cyc(5);
      e0 = edges;
      rlen = 0;
      kick();
      for (int i = 0; i < 900 && wrst !== 1'b1; i++) @(posedge clk);
      chk("ticks", 8'(edges - e0 >= n && edges - e0 <= n + 1), 1);
      for (int i = 0; i < 20 && wrst === 1'b1; i++) @(posedge clk);
      #1;
      chk("reset len", 8'(rlen), WDTLK_RST_CLK);
      chk("idle after", act, 0);
      for (int i = 0; i < 20 && wopen !== 1'b1; i++) @(posedge clk);
   endtask
   initial begin
      cyc(10);
      rst <= 1'b0;
      cyc(1);
      start <= 1'b1;
      cyc(1);
      start <= 1'b0;
      cyc(3);
      rd <= 1'b1;
      bank <= WDTLK_MODE_BANK;
      addr <= WDTLK_MODE_ADDR;
      cyc(1);
      #1;
      chk("hit", hit, 1);
      chk("rdata", rdata, 0);
      cyc(1);
      bank <= 4'hE;
      cyc(1);
      #1;
      chk("miss", hit, 0);
      cyc(1);
      rd <= 1'b0;
      wreg(8'hF5);
      for (int i = 0; i < 200 && wopen === 1'b1; i++) @(posedge clk);
      chk("window", 8'(opens), 8'(WDTLK_WIN_CLK));
      wreg(8'h03);
      repeat (20) @(posedge rc);
      chk("no start", 8'(rsts), 0);
      chk("inactive", act, 0);
      kick();
      repeat (6) begin
         repeat (3) @(posedge rc);
         kick();
      end
      chk("refresh", 8'(rsts), 0);
      halt <= 1'b1;
      meas(T1);
      stop <= 1'b1;
      for (int t = 0; t < 4; t++) begin
         wreg(8'(t) | 8'h0C);
         meas(tk[t]);
      end
      wreg(8'h00);
      kick();
      r0 = rsts;
      stop <= 1'b0;
      repeat (20) @(posedge rc);
      chk("halt hold", 8'(rsts - r0), 0);
      cyc(1);
      halt <= 1'b0;
      stop <= 1'b1;
      repeat (20) @(posedge rc);
      chk("stop hold", 8'(rsts - r0), 0);
      cyc(1);
      stop <= 1'b0;
      for (int i = 0; i < 200 && wrst !== 1'b1; i++) @(posedge clk);
      #1;
      chk("resume", wrst, 1);
      summarize();
   end
   // Hang guard, far beyond the expected run
   initial begin
      #1000000;
      fails++;
      summarize();
   end
endmodule
`default_nettype wire
